/* File: hdl/pgto_map.vh */
`ifndef PGTO_MAP_VH
`define PGTO_MAP_VH
// ==========================================================================
// Register offsets (word index = byte address / 4 not used; plain port)
`define PGTO_REG_CTRL 8'h00
`define PGTO_REG_PRBS_ORDER 8'h04
`define PGTO_REG_PRBS_WORD 8'h08
`define PGTO_REG_ZERO_SUBSTITUTION_POSITION_SEL 8'h0c
`define PGTO_REG_ZERO_SUBSTITUTION_POSITION_POS 8'h10
`define PGTO_REG_MARK_DENSITY_POSITION_SEL 8'h14
`define PGTO_REG_MARK_DENSITY_POSITION_POS 8'h18
`define PGTO_REG_USER_PATTERN_POSITION_SEL 8'h1c
`define PGTO_REG_USER_PATTERN_POSITION_POS 8'h20
`define PGTO_REG_STATUS 8'h24
`define PGTO_REG_RATIO 8'h28
`define PGTO_REG_PAT_LEN 8'h2c
// ==========================================================================
// Control register fields
`define PGTO_CTRL_DIVMODE 0
`define PGTO_CTRL_RATIO32 1
`define PGTO_CTRL_SOP 2
`define PGTO_CTRL_NOTRACK 3
`define PGTO_CTRL_SRC_LO 4
`define PGTO_CTRL_SRC_HI 6
`define PGTO_CTRL_RESET 32'h00000000
// Pattern source codes
`define PGTO_SRC_PRBS 3'h0
`define PGTO_SRC_ZERO_SUBSTITUTION_POSITION 3'h1
`define PGTO_SRC_MARK_DENSITY_POSITION 3'h2
`define PGTO_SRC_USER 3'h3
`define PGTO_SRC_ALT 3'h4
// Division ratios
`define PGTO_RATIO_LO 32'h00000008
`define PGTO_RATIO_HI 32'h00000020
`define PGTO_NAN_CODE 32'hffffffff
`define PGTO_PRBS_ORDER_RESET 8'h07
`define PGTO_PAT_LEN_RESET 32'h0000007f
`define PGTO_STORES 13
`define PGTO_STORE_NVRAM_LAST 4
`define PGTO_STORE_DISK_FIRST 5
`endif

/* File: hdl/pgto_store_mem.v */
`default_nettype none
// ==========================================================================
// Store positions: index 0 active, 1-4 kept, 5-12 disk image
module pgto_store_mem #(
  parameter DEPTH = 13,
  parameter AW = 4,
  parameter DW = 32
) (
  input wire clock, // System clock
  input wire reset_n, // Async reset, active low
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Write index
  input wire [DW-1:0] wr_data, // Write data
  input wire [AW-1:0] rd_addr, // Read index
  output reg [DW-1:0] rd_data // Registered read data
);
  reg [DW-1:0] mem [0:DEPTH-1];
  integer i;

  // Write and registered read; all stores 0..12 reset to zero
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= {DW{1'b0}};
      end
      rd_data <= {DW{1'b0}};
    end else begin
      if (wr_en && (wr_addr < DEPTH)) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= (rd_addr < DEPTH) ? mem[rd_addr] : {DW{1'b0}};
    end
  end
endmodule // pgto_store_mem
`default_nettype wire

/* File: hdl/pgto_trigger.v */
// Notes on behaviour
// - Two modes, pattern and divided clock; pattern mode after reset.
// - Pattern mode pulses trigger on each match of selected sequence.
// - Divide ratio accepts only 8 or 32; reset gives 8.
// - Report clock-to-trigger ratio for the selected pattern.
// - Alternate pattern with half-change trigger reports not-a-number code.
// - PRBS match order limited to 7, 10, 15, 23 or 31.
// - Match word has order bits; all-ones word is rejected.
// - Zero-substitution position per order 7,10,11,13; resets to zero.
// - Mark-density position per order 7,10,11,13; resets to zero.
// - User position per store 0..12; stores 0..4 reset to zero.
// - Store 0 active, 1-4 non-volatile, 5-12 disk.
// - Alternate pattern: start-of-pattern pulse or half-change toggle.
// - Band code 0 means through path; delay adjust then unavailable.
// - Band codes 1, 2, 3 mark low, middle, high pass bands.
// - Inverted clock levels accepted only while tracking is off.
`default_nettype none
`include "pgto_map.vh"
module pgto_trigger #(
  parameter POS_W = 32
) (
  input wire clock, // System clock, 100 MHz
  input wire reset_n, // Async reset, active low
  input wire [7:0] addr, // Register byte address
  input wire [31:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  output reg [31:0] rdata, // Read data, cycle after strobe
  input wire data_bit, // Transmitted data bit, same domain
  input wire bit_valid, // One bit per strobe
  input wire pattern_start, // First bit of pattern, same domain
  input wire alt_half_b, // High while half B is sent
  input wire [1:0] band_in, // Clock path band, from another domain
  input wire inv_clk_set, // Request to set inverted clock level
  input wire [15:0] inv_clk_level, // Requested level word
  output reg [15:0] inv_clk_applied, // Level applied to inverted clock
  output wire tracking, // Inverted clock tracks true clock
  output wire delay_adjust_ok, // Clock-to-data delay adjustable
  output reg trigger_out // Trigger output
);
  // ========================================================================
  // Configuration
  reg [31:0] ctrl;
  reg [7:0] prbs_order;
  reg [31:0] prbs_word;
  reg [1:0] zero_substitution_position_sel;
  reg [1:0] mark_density_position_sel;
  reg [3:0] user_pattern_position_sel;
  reg [POS_W-1:0] zero_substitution_position_pos [0:3];
  reg [POS_W-1:0] mark_density_position_pos [0:3];
  reg [31:0] pat_len;
  reg [1:0] band_meta;
  reg [1:0] band;
  reg [31:0] shift;
  reg [POS_W-1:0] pos_cnt;
  reg [4:0] div_cnt;
  reg half_q;
  reg [31:0] next_rdata;
  integer k;

  wire div_mode = ctrl[`PGTO_CTRL_DIVMODE];
  wire ratio32 = ctrl[`PGTO_CTRL_RATIO32];
  wire sop = ctrl[`PGTO_CTRL_SOP];
  wire [2:0] src = ctrl[`PGTO_CTRL_SRC_HI:`PGTO_CTRL_SRC_LO];
  wire [31:0] up_rd;
  // user position must lie below pattern length
  wire up_wr = wr && (addr == `PGTO_REG_USER_PATTERN_POSITION_POS) && (wdata < pat_len);
  assign tracking = ~ctrl[`PGTO_CTRL_NOTRACK];

  // Mask of valid match bits for a given order
  function [31:0] order_mask;
    input [7:0] ord;
    begin
      order_mask = (ord >= 8'd32) ? 32'hffffffff :
                   ((32'h00000001 << ord[4:0]) - 32'h00000001);
    end
  endfunction

  function prbs_order_ok;
    input [7:0] ord;
    begin
      prbs_order_ok = (ord == 8'd7) || (ord == 8'd10) || (ord == 8'd15) ||
                      (ord == 8'd23) || (ord == 8'd31);
    end
  endfunction

  // Substitution order to slot: 7,10,11,13 map to 0..3
  function [2:0] sub_slot;
    input [7:0] ord;
    begin
      case (ord)
        8'd7: sub_slot = 3'h0;
        8'd10: sub_slot = 3'h1;
        8'd11: sub_slot = 3'h2;
        8'd13: sub_slot = 3'h3;
        default: sub_slot = 3'h4;
      endcase
    end
  endfunction

  // Slot of the written substitution order, 4 means not supported
  wire [2:0] wr_slot = sub_slot(wdata[7:0]);

  // index 0 active, 1..4 NVRAM, 5..12 disk
  pgto_store_mem #(
    .DEPTH(`PGTO_STORES),
    .AW(4),
    .DW(32)
  ) u_store (
    .clock(clock),
    .reset_n(reset_n),
    .wr_en(up_wr),
    .wr_addr(user_pattern_position_sel),
    .wr_data(wdata),
    .rd_addr(user_pattern_position_sel),
    .rd_data(up_rd)
  );

  // ========================================================================
  // Register writes; illegal values are ignored, old value kept; control takes any low 7 bits
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      // pattern mode, ratio 8, half-change, tracking
      ctrl <= `PGTO_CTRL_RESET;
      prbs_order <= `PGTO_PRBS_ORDER_RESET;
      prbs_word <= 32'h00000000;
      zero_substitution_position_sel <= 2'h0;
      mark_density_position_sel <= 2'h0;
      user_pattern_position_sel <= 4'h0;
      pat_len <= `PGTO_PAT_LEN_RESET;
      for (k = 0; k < 4; k = k + 1) begin
        zero_substitution_position_pos[k] <= {POS_W{1'b0}};
        mark_density_position_pos[k] <= {POS_W{1'b0}};
      end
    end else if (wr) begin
      case (addr)
        `PGTO_REG_CTRL: begin
          ctrl <= {25'h0, wdata[6:0]};
        end
        `PGTO_REG_PRBS_ORDER: begin
          if (prbs_order_ok(wdata[7:0])) begin
            prbs_order <= wdata[7:0];
            prbs_word <= prbs_word & order_mask(wdata[7:0]);
          end
        end
        `PGTO_REG_PRBS_WORD: begin
          if ((wdata & order_mask(prbs_order)) != order_mask(prbs_order)) begin
            prbs_word <= wdata & order_mask(prbs_order);
          end
        end
        `PGTO_REG_ZERO_SUBSTITUTION_POSITION_SEL: begin
          if (wr_slot != 3'h4) begin
            zero_substitution_position_sel <= wr_slot[1:0];
          end
        end
        `PGTO_REG_MARK_DENSITY_POSITION_SEL: begin
          if (wr_slot != 3'h4) begin
            mark_density_position_sel <= wr_slot[1:0];
          end
        end
        `PGTO_REG_USER_PATTERN_POSITION_SEL: begin
          if (wdata[3:0] <= 4'd12) begin
            user_pattern_position_sel <= wdata[3:0];
          end
        end
        `PGTO_REG_ZERO_SUBSTITUTION_POSITION_POS: begin
          if (wdata < pat_len) begin
            zero_substitution_position_pos[zero_substitution_position_sel] <= wdata[POS_W-1:0];
          end
        end
        `PGTO_REG_MARK_DENSITY_POSITION_POS: begin
          if (wdata < pat_len) begin
            mark_density_position_pos[mark_density_position_sel] <= wdata[POS_W-1:0];
          end
        end
        `PGTO_REG_PAT_LEN: begin
          if (wdata != 32'h00000000) begin
            pat_len <= wdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // only 8 or 32 representable, ratio bit picks between them
  wire [4:0] div_top = ratio32 ? 5'd31 : 5'd7;

  // ========================================================================
  // Band code synchroniser; first stage read only by the second
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      band_meta <= 2'h0;
      band <= 2'h0;
    end else begin
      band_meta <= band_in;
      band <= band_meta;
    end
  end
  assign delay_adjust_ok = (band != 2'h0);

  // ========================================================================
  // inverted clock level only while tracking is off
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      inv_clk_applied <= 16'h0000;
    end else if (inv_clk_set && !tracking) begin
      inv_clk_applied <= inv_clk_level;
    end
  end

  // Selected trigger position for positional sources
  reg [POS_W-1:0] sel_pos;
  always @* begin
    case (src)
      `PGTO_SRC_ZERO_SUBSTITUTION_POSITION: sel_pos = zero_substitution_position_pos[zero_substitution_position_sel];
      `PGTO_SRC_MARK_DENSITY_POSITION: sel_pos = mark_density_position_pos[mark_density_position_sel];
      `PGTO_SRC_USER: sel_pos = up_rd[POS_W-1:0];
      default: sel_pos = {POS_W{1'b0}};
    endcase
  end

  // ========================================================================
  // Trigger generation; one flop so trigger_out comes from a register
  wire [31:0] next_shift = {shift[30:0], data_bit};
  wire prbs_hit = ((next_shift & order_mask(prbs_order)) == prbs_word);
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shift <= 32'h00000000;
      pos_cnt <= {POS_W{1'b0}};
      div_cnt <= 5'h00;
      half_q <= 1'b0;
      trigger_out <= 1'b0;
    end else if (div_mode) begin
      // divided clock, square wave at bit strobe rate over ratio
      if (bit_valid) begin
        div_cnt <= (div_cnt >= div_top) ? 5'h00 : div_cnt + 5'd1;
        trigger_out <= (div_cnt < (div_top >> 1)) ||
                       (div_cnt == div_top);
      end
    end else if (bit_valid) begin
      shift <= next_shift;
      half_q <= alt_half_b;
      if (pattern_start) begin
        pos_cnt <= {{(POS_W-1){1'b0}}, 1'b1};
      end else begin
        pos_cnt <= pos_cnt + {{(POS_W-1){1'b0}}, 1'b1};
      end
      case (src)
        `PGTO_SRC_PRBS: begin
          trigger_out <= prbs_hit;
        end
        `PGTO_SRC_ALT: begin
          trigger_out <= sop ? pattern_start : alt_half_b;
        end
        default: begin
          trigger_out <= pattern_start ? (sel_pos == {POS_W{1'b0}}) :
                         (pos_cnt == sel_pos);
        end
      endcase
    end else begin
      trigger_out <= (src == `PGTO_SRC_ALT) && !sop && half_q;
    end
  end

  // ========================================================================
  // Read path; data stand in the cycle after the strobe only
  always @* begin
    next_rdata = 32'h00000000;
    case (addr)
      `PGTO_REG_CTRL: next_rdata = ctrl;
      `PGTO_REG_PRBS_ORDER: next_rdata = {24'h0, prbs_order};
      `PGTO_REG_PRBS_WORD: next_rdata = prbs_word;
      `PGTO_REG_ZERO_SUBSTITUTION_POSITION_SEL: next_rdata = {30'h0, zero_substitution_position_sel};
      `PGTO_REG_ZERO_SUBSTITUTION_POSITION_POS: next_rdata = zero_substitution_position_pos[zero_substitution_position_sel];
      `PGTO_REG_MARK_DENSITY_POSITION_SEL: next_rdata = {30'h0, mark_density_position_sel};
      `PGTO_REG_MARK_DENSITY_POSITION_POS: next_rdata = mark_density_position_pos[mark_density_position_sel];
      `PGTO_REG_USER_PATTERN_POSITION_SEL: next_rdata = {28'h0, user_pattern_position_sel};
      `PGTO_REG_USER_PATTERN_POSITION_POS: next_rdata = up_rd;
      `PGTO_REG_STATUS: next_rdata = {28'h0, delay_adjust_ok, tracking, band};
      `PGTO_REG_RATIO: begin
        // ratio report, NaN code for alternate half-change
        if (div_mode) begin
          next_rdata = ratio32 ? `PGTO_RATIO_HI : `PGTO_RATIO_LO;
        end else if (src == `PGTO_SRC_ALT && !sop) begin
          next_rdata = `PGTO_NAN_CODE;
        end else begin
          next_rdata = pat_len;
        end
      end
      `PGTO_REG_PAT_LEN: next_rdata = pat_len;
      default: next_rdata = 32'h00000000;
    endcase
    if (!rd) begin
      next_rdata = 32'h00000000;
    end
  end

  // The user store output is already registered from the selected index,
  // so a read answers in the next cycle; a select change needs one gap
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= next_rdata;
    end
  end
endmodule // pgto_trigger
`default_nettype wire

/* File: tb/pgto_trig_rx.sv */
`default_nettype none
// ==========================================================================
// Receiving instrument: counts trigger rises and their spacing
module pgto_trig_rx (
  input wire logic clock, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic trigger_out, // Trigger from the block
  output var int rises, // Rising edges seen
  output var int period // Cycles between the last two rises
);
  timeunit 1ns;
  timeprecision 1ps;
  int since;
  logic last;
  // Edge detector; pulse or square wave alike show their rate by rises
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rises <= 0;
      period <= 0;
      since <= 0;
      last <= 1'b0;
    end else begin
      last <= trigger_out;
      since <= since + 1;
      if (trigger_out && !last) begin
        rises <= rises + 1;
        period <= since + 1;
        since <= 0;
      end
    end
  end
endmodule // pgto_trig_rx
`default_nettype wire

/* File: tb/pgto_trigger_properties.sv */
`default_nettype none
`include "pgto_map.vh"
// ==========================================================================
// Port checker for the trigger block
module pgto_trigger_properties (
  input wire logic clock, // Clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [7:0] addr, // Address
  input wire logic [31:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  input wire logic [31:0] rdata, // Read data
  input wire logic data_bit, // Data bit
  input wire logic bit_valid, // Bit strobe
  input wire logic pattern_start, // Pattern start
  input wire logic alt_half_b, // Half B flag
  input wire logic [1:0] band_in, // Band code in
  input wire logic inv_clk_set, // Level request
  input wire logic [15:0] inv_clk_level, // Requested level
  input wire logic [15:0] inv_clk_applied, // Applied level
  input wire logic tracking, // Tracking flag
  input wire logic delay_adjust_ok, // Delay adjust flag
  input wire logic trigger_out // Trigger
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl;
  logic [31:0] plen;
  logic [31:0] exp_ratio;
  // Shadow of control and length writes, so ratio reads can be predicted
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `PGTO_CTRL_RESET;
      plen <= `PGTO_PAT_LEN_RESET;
    end else if (wr && addr == `PGTO_REG_CTRL) begin
      ctrl <= wdata;
    end else if (wr && addr == `PGTO_REG_PAT_LEN && wdata != 32'h0) begin
      plen <= wdata;
    end
  end
  // Divided mode wins over the alternate half-change case
  always_comb begin
    if (ctrl[0])
      exp_ratio = ctrl[1] ? `PGTO_RATIO_HI : `PGTO_RATIO_LO;
    else if (ctrl[6:4] == `PGTO_SRC_ALT && !ctrl[2])
      exp_ratio = `PGTO_NAN_CODE;
    else
      exp_ratio = plen;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_rdata_idle: assert property (
    !$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
  chk_ratio_read: assert property (
    rd && addr == `PGTO_REG_RATIO |=> rdata == $past(exp_ratio))
    else $error("ratio report wrong");
  chk_track_ctrl: assert property (
    wr && addr == `PGTO_REG_CTRL |=> tracking == !$past(wdata[3]))
    else $error("tracking not from control");
  chk_inv_refused: assert property (
    inv_clk_set && tracking |=> $stable(inv_clk_applied))
    else $error("level taken while tracking");
  chk_inv_applied: assert property (
    inv_clk_set && !tracking |=> inv_clk_applied == $past(inv_clk_level))
    else $error("level not applied");
  chk_band_zero: assert property (
    (band_in == 2'h0) [*4] |-> !delay_adjust_ok)
    else $error("delay adjust with through path");
  chk_band_live: assert property (
    (band_in != 2'h0) [*4] |-> delay_adjust_ok)
    else $error("delay adjust missing in band");
  chk_trig_cause: assert property (
    ctrl[6:4] != `PGTO_SRC_ALT && !$past(wr) && !$past(wr, 2)
    && $rose(trigger_out) |-> $past(bit_valid))
    else $error("trigger without bit");
endmodule // pgto_trigger_properties
bind pgto_trigger pgto_trigger_properties u_props (.clock(clock),
  .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .data_bit(data_bit), .bit_valid(bit_valid),
  .pattern_start(pattern_start), .alt_half_b(alt_half_b),
  .band_in(band_in), .inv_clk_set(inv_clk_set),
  .inv_clk_level(inv_clk_level), .inv_clk_applied(inv_clk_applied),
  .tracking(tracking), .delay_adjust_ok(delay_adjust_ok),
  .trigger_out(trigger_out));
`default_nettype wire

/* File: tb/tb_pgto_trigger.sv */
`default_nettype none
`include "pgto_map.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  err_total++; $display("wrong value %s exp %h got %h", n, e, s); end end
// ==========================================================================
// Bench top
module tb_pgto_trigger;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, wr, rd, data_bit, bit_valid, pattern_start;
  logic alt_half_b, inv_clk_set, tracking, delay_adjust_ok, trigger_out;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [1:0] band_in;
  logic [15:0] inv_clk_level, inv_clk_applied;
  int err_total, tests_run, rises, period, r0;
  logic [7:0] ords[4] = '{8'h07, 8'h0a, 8'h0b, 8'h0d};
  logic [7:0] prbs[5] = '{8'h07, 8'h0a, 8'h0f, 8'h17, 8'h1f};
  pgto_trigger #(.POS_W(32)) DUT (.clock(clock), .reset_n(reset_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .data_bit(data_bit), .bit_valid(bit_valid),
    .pattern_start(pattern_start), .alt_half_b(alt_half_b),
    .band_in(band_in), .inv_clk_set(inv_clk_set),
    .inv_clk_level(inv_clk_level), .inv_clk_applied(inv_clk_applied),
    .tracking(tracking), .delay_adjust_ok(delay_adjust_ok),
    .trigger_out(trigger_out));
  pgto_trig_rx u_rx (.clock(clock), .reset_n(reset_n),
    .trigger_out(trigger_out), .rises(rises), .period(period));
  // ========================================================================
  // Bus and stream tasks
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock); wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock); addr <= a; rd <= 1'b1;
    @(posedge clock); rd <= 1'b0;
    @(negedge clock);
    `CHK($sformatf("reg %h", a), e, rdata)
  endtask
  task automatic send(input logic [31:0] w, input int n, input logic st);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clock); data_bit <= w[i]; bit_valid <= 1'b1;
      pattern_start <= st && (i == n - 1);
    end
  endtask
  // Released data line shows the inverse, never a stale value
  task automatic idle();
    @(posedge clock); bit_valid <= 1'b0; pattern_start <= 1'b0;
    data_bit <= ~data_bit;
    repeat (3) @(posedge clock);
  endtask
  task automatic inv_pulse();
    @(posedge clock); inv_clk_level <= 16'h1234; inv_clk_set <= 1'b1;
    @(posedge clock); inv_clk_set <= 1'b0;
    @(negedge clock);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ========================================================================
  // Clock, watchdog and test sequence
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    err_total++;
    end_sim();
  end
  initial begin
    {wr, rd, data_bit, bit_valid, pattern_start} = 5'h00;
    {alt_half_b, inv_clk_set, addr, wdata, band_in} = '0;
    inv_clk_level = 16'h0000;
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    rchk(`PGTO_REG_CTRL, 32'h0);
    rchk(`PGTO_REG_PRBS_WORD, 32'h0);
    rchk(`PGTO_REG_RATIO, 32'h7f);
    `CHK("tracking", 1'b1, tracking)
    $display("test reset done");
    foreach (prbs[i]) begin
      wreg(`PGTO_REG_PRBS_ORDER, {24'h0, prbs[i]});
      rchk(`PGTO_REG_PRBS_ORDER, {24'h0, prbs[i]});
    end
    wreg(`PGTO_REG_PRBS_ORDER, 32'h9);
    rchk(`PGTO_REG_PRBS_ORDER, 32'h1f);
    wreg(`PGTO_REG_PRBS_ORDER, 32'h7);
    wreg(`PGTO_REG_PRBS_WORD, 32'h5);
    wreg(`PGTO_REG_PRBS_WORD, 32'h7f);
    rchk(`PGTO_REG_PRBS_WORD, 32'h5);
    r0 = rises;
    send(32'h5, 7, 1'b0);
    send(32'h0, 8, 1'b0);
    idle();
    `CHK("match rises", r0 + 1, rises)
    $display("test prbs done");
    for (int b = 0; b < 2; b++) foreach (ords[i]) begin
      wreg(`PGTO_REG_ZERO_SUBSTITUTION_POSITION_SEL + 8'(b * 8), {24'h0, ords[i]});
      rchk(`PGTO_REG_ZERO_SUBSTITUTION_POSITION_POS + 8'(b * 8), 32'h0);
      wreg(`PGTO_REG_ZERO_SUBSTITUTION_POSITION_POS + 8'(b * 8), 32'h5);
      wreg(`PGTO_REG_ZERO_SUBSTITUTION_POSITION_POS + 8'(b * 8), 32'h7f);
      rchk(`PGTO_REG_ZERO_SUBSTITUTION_POSITION_POS + 8'(b * 8), 32'h5);
    end
    for (int s = 0; s < 5; s++) begin
      wreg(`PGTO_REG_USER_PATTERN_POSITION_SEL, 32'(s));
      rchk(`PGTO_REG_USER_PATTERN_POSITION_POS, 32'h0);
    end
    wreg(`PGTO_REG_USER_PATTERN_POSITION_SEL, 32'hc);
    wreg(`PGTO_REG_USER_PATTERN_POSITION_POS, 32'h9);
    wreg(`PGTO_REG_USER_PATTERN_POSITION_SEL, 32'hd);
    rchk(`PGTO_REG_USER_PATTERN_POSITION_POS, 32'h9);
    $display("test positions done");
    for (int k = 0; k < 2; k++) begin
      wreg(`PGTO_REG_CTRL, 32'(1 + 2 * k));
      repeat (5) send(32'h0, 24, 1'b0);
      idle();
      rchk(`PGTO_REG_RATIO, k ? 32'h20 : 32'h8);
      `CHK("period", k ? 32 : 8, period)
    end
    wreg(`PGTO_REG_CTRL, 32'h40);
    rchk(`PGTO_REG_RATIO, 32'hffffffff);
    wreg(`PGTO_REG_CTRL, 32'h44);
    rchk(`PGTO_REG_RATIO, 32'h7f);
    $display("test ratio done");
    wreg(`PGTO_REG_CTRL, 32'h30);
    wreg(`PGTO_REG_PAT_LEN, 32'h10);
    wreg(`PGTO_REG_USER_PATTERN_POSITION_SEL, 32'h0);
    wreg(`PGTO_REG_USER_PATTERN_POSITION_POS, 32'h3);
    r0 = rises;
    repeat (3) send(32'h0, 16, 1'b1);
    idle();
    `CHK("frame rises", r0 + 3, rises)
    `CHK("frame period", 16, period)
    $display("test restart done");
    for (int b = 0; b < 4; b++) begin
      @(posedge clock); band_in <= 2'(b);
      repeat (6) @(posedge clock);
      rchk(`PGTO_REG_STATUS, {28'h0, b != 0, 1'b1, 2'(b)});
    end
    $display("test band done");
    inv_pulse();
    `CHK("applied", 16'h0000, inv_clk_applied)
    wreg(`PGTO_REG_CTRL, 32'h8);
    inv_pulse();
    `CHK("applied", 16'h1234, inv_clk_applied)
    `CHK("tracking", 1'b0, tracking)
    $display("test tracking done");
    end_sim();
  end
endmodule // tb_pgto_trigger
`default_nettype wire
